// *** hdl/sw_interlock_pkg.sv ***
// Constants, field layouts and codes shared by the switching command interlock checker
package sw_interlock_pkg;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CFG = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_VDN = 8'h0c;

   // Control register fields
   localparam int CTRL_AUTH_LSB = 0;
   localparam int CTRL_LOCAL_NI = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0007;

   // Configuration register fields, one bit per switching device except the two pickup blocking bits
   localparam int CFG_CHK_LOCAL_LSB = 0;
   localparam int CFG_CHK_LRE_LSB = 4;
   localparam int CFG_REL_CLOSE_LSB = 8;
   localparam int CFG_REL_OPEN_LSB = 12;
   localparam int CFG_SETACT_LSB = 16;
   localparam int CFG_BLK_CLOSE = 20;
   localparam int CFG_BLK_OPEN = 21;
   localparam logic [31:0] CFG_RESET = 32'h003f_ffff;
   localparam logic [31:0] CFG_MASK = 32'h003f_ffff;

   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_LOGGED = 1;
   localparam int STAT_UNLOCK = 2;
   localparam int STAT_DEV_LSB = 4;
   localparam int STAT_RSN_LSB = 8;

   // ****************************************************************
   // Codes
   // ****************************************************************
   localparam logic [1:0] SRC_LOCAL = 2'h0;
   localparam logic [1:0] SRC_REMOTE = 2'h1;
   localparam logic [1:0] SRC_ENG = 2'h2;
   localparam logic [1:0] SRC_AUTO = 2'h3;

   localparam logic [1:0] AUTH_OFF = 2'h0;
   localparam logic [1:0] AUTH_LOCAL = 2'h1;
   localparam logic [1:0] AUTH_REMOTE = 2'h2;

   localparam logic [3:0] RSN_NONE = 4'h0;
   localparam logic [3:0] RSN_LOCAL_CTL = 4'h1;
   localparam logic [3:0] RSN_REMOTE_CTL = 4'h2;
   localparam logic [3:0] RSN_ENG_CTL = 4'h3;
   localparam logic [3:0] RSN_NOT_REG = 4'h4;
   localparam logic [3:0] RSN_BUSY = 4'h5;
   localparam logic [3:0] RSN_PROT = 4'h6;
   localparam logic [3:0] RSN_ZONE = 4'h7;
   localparam logic [3:0] RSN_SET_ACT = 4'h8;

   // Double-point position: open and closed; 00 and 11 are intermediate
   localparam logic [1:0] POS_OPEN = 2'h1;
   localparam logic [1:0] POS_CLOSED = 2'h2;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } state_t;

endpackage

// *** hdl/sw_interlock.sv ***
// Switching command interlock checker: authority, mode, zone, blocking, position checks
//
// Functional notes
// RL1: Authority priority local, engineering PC, remote.
// RL2: Local authority object gates only local commands.
// RL3: Store PC number at logon; match; clear.
// RL4: Local authority: remote/PC rejected, unregistered PC.
// RL5: Remote, no PC: local rejected, PC unregistered.
// RL6: Remote with PC: only PC commands enabled.
// RL7: No local-status check enables remote-control rejects.
// RL8: No authority check enables local/PC-control rejects.
// RL9: Automatic commands always pass authority check.
// RL10: Local mode setting; remote unlock by command.
// RL11: Remote unlock covers one operation only.
// RL12: Unlock honoured only for same source.
// RL13: Zone release configurable per device, per direction.
// RL14: Release status sampled every cycle while executing.
// RL15: One command at a time; others blocked.
// RL16: Pickup blocks close and trip separately, configurable.
// RL17: Pickup aborts operation in progress.
// RL18: Refuse command to position already held.
// RL19: Skip position check in intermediate position.
// RL20: Bypass per command code or switching mode.
// RL21: Emit feedback messages carrying the cause.
// RL22: One accept/reject per command with reason.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps

module sw_interlock (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Command sources
   input wire logic cmd_valid_i,
   input wire logic [1:0] command_source_i,
   input wire logic [1:0] cmd_dev_i,
   input wire logic cmd_dir_i,
   input wire logic [7:0] cmd_vdn_i,
   input wire logic cmd_bypass_i,
   input wire logic unlock_i,
   input wire logic [1:0] unlock_source_i,
   input wire logic logon_i,
   input wire logic logoff_i,
   input wire logic [7:0] logon_vdn_i,
   // Plant pins
   input wire logic [7:0] pos_i,
   input wire logic [3:0] rel_close_i,
   input wire logic [3:0] rel_open_i,
   input wire logic pickup_i,
   // Decision and feedback
   output logic dec_valid_o,
   output logic dec_accept_o,
   output logic [3:0] dec_reason_o,
   output logic fb_valid_o,
   output logic fb_ok_o,
   output logic [3:0] fb_cause_o,
   output logic [1:0] fb_dev_o,
   output logic [3:0] close_o,
   output logic [3:0] open_o
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Authority table; higher zones win (local, then PC, then remote)
   function automatic logic [3:0] auth_check(
      input logic [1:0] auth,
      input logic [1:0] src,
      input logic logged,
      input logic vmatch,
      input logic chk_l,
      input logic chk_lre);
      logic [3:0] r;
      r = sw_interlock_pkg::RSN_NONE;
      if (src == sw_interlock_pkg::SRC_AUTO) begin
         r = sw_interlock_pkg::RSN_NONE; // RL9
      end else if (src == sw_interlock_pkg::SRC_ENG && !vmatch) begin
         r = sw_interlock_pkg::RSN_NOT_REG; // RL3
      end else if (auth == sw_interlock_pkg::AUTH_LOCAL) begin
         if (src != sw_interlock_pkg::SRC_LOCAL && chk_lre) begin
            r = sw_interlock_pkg::RSN_LOCAL_CTL; // RL4 RL8
         end
      end else if (auth == sw_interlock_pkg::AUTH_REMOTE) begin
         if (logged) begin
            if (src == sw_interlock_pkg::SRC_LOCAL && chk_l) begin
               r = sw_interlock_pkg::RSN_ENG_CTL; // RL6 RL7
            end else if (src == sw_interlock_pkg::SRC_REMOTE && chk_lre) begin
               r = sw_interlock_pkg::RSN_ENG_CTL; // RL6 RL8
            end
         end else if (src == sw_interlock_pkg::SRC_LOCAL && chk_l) begin
            r = sw_interlock_pkg::RSN_REMOTE_CTL; // RL5 RL7
         end
      end
      return r;
   endfunction

   // Desired double-point code for a direction
   function automatic logic [1:0] target_pos(input logic dir);
      return dir ? sw_interlock_pkg::POS_CLOSED : sw_interlock_pkg::POS_OPEN;
   endfunction

   // Release enable and release status of one device in one direction
   function automatic logic zone_fail(
      input logic [3:0] en_c,
      input logic [3:0] en_o,
      input logic [3:0] rel_c,
      input logic [3:0] rel_o,
      input logic [1:0] dev,
      input logic dir);
      return dir ? (en_c[dev] && !rel_c[dev]) : (en_o[dev] && !rel_o[dev]);
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [16:0] sync1_ff;
   logic [16:0] sync2_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] cfg_ff;
   logic [31:0] reg_rdata_ff;
   logic logged_ff;
   logic [7:0] vdn_ff;
   logic unlock_ff;
   logic [1:0] unlock_src_ff;
   sw_interlock_pkg::state_t state_ff;
   sw_interlock_pkg::state_t nxt_state;
   logic [1:0] dev_ff;
   logic dir_ff;
   logic il_ff;
   logic [3:0] last_rsn_ff;
   logic dec_valid_ff;
   logic dec_accept_ff;
   logic [3:0] dec_reason_ff;
   logic fb_valid_ff;
   logic fb_ok_ff;
   logic [3:0] fb_cause_ff;
   logic [1:0] fb_dev_ff;
   logic [3:0] close_ff;
   logic [3:0] open_ff;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   // Position, release and pickup come from the plant, asynchronous here
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_ff <= 17'h0_0000;
         sync2_ff <= 17'h0_0000;
      end else begin
         sync1_ff <= {pickup_i, rel_open_i, rel_close_i, pos_i};
         sync2_ff <= sync1_ff;
      end
   end

   wire [7:0] pos_s = sync2_ff[7:0];
   wire [3:0] rel_c_s = sync2_ff[11:8];
   wire [3:0] rel_o_s = sync2_ff[15:12];
   wire pickup_s = sync2_ff[16];

   // ****************************************************************
   // Register decode
   // ****************************************************************
   wire wr_ctrl = reg_wr_i && reg_addr_i == sw_interlock_pkg::ADDR_CTRL;
   wire wr_cfg = reg_wr_i && reg_addr_i == sw_interlock_pkg::ADDR_CFG;
   wire [1:0] auth = ctrl_ff[sw_interlock_pkg::CTRL_AUTH_LSB +: 2];
   wire local_ni = ctrl_ff[sw_interlock_pkg::CTRL_LOCAL_NI];
   wire [3:0] chk_l = cfg_ff[sw_interlock_pkg::CFG_CHK_LOCAL_LSB +: 4];
   wire [3:0] chk_lre = cfg_ff[sw_interlock_pkg::CFG_CHK_LRE_LSB +: 4];
   wire [3:0] rel_en_c = cfg_ff[sw_interlock_pkg::CFG_REL_CLOSE_LSB +: 4]; // RL13
   wire [3:0] rel_en_o = cfg_ff[sw_interlock_pkg::CFG_REL_OPEN_LSB +: 4]; // RL13
   wire [3:0] setact_en = cfg_ff[sw_interlock_pkg::CFG_SETACT_LSB +: 4];
   wire blk_c = cfg_ff[sw_interlock_pkg::CFG_BLK_CLOSE];
   wire blk_o = cfg_ff[sw_interlock_pkg::CFG_BLK_OPEN];
   wire busy = state_ff == sw_interlock_pkg::ST_EXEC;

   // Status word shows the block's live state
   wire [31:0] stat_word = {20'h0_0000, last_rsn_ff, 2'h0, dev_ff, 1'b0, unlock_ff,
      logged_ff, busy};

   wire [31:0] rd_mux =
      (reg_addr_i == sw_interlock_pkg::ADDR_CTRL) ? ctrl_ff :
      (reg_addr_i == sw_interlock_pkg::ADDR_CFG) ? cfg_ff :
      (reg_addr_i == sw_interlock_pkg::ADDR_STAT) ? stat_word :
      (reg_addr_i == sw_interlock_pkg::ADDR_VDN) ? {24'h00_0000, vdn_ff} : 32'h0000_0000;

   // ****************************************************************
   // Command decision
   // ****************************************************************
   wire [1:0] cur_pos = pos_s[2 * cmd_dev_i +: 2];
   wire vmatch = logged_ff && cmd_vdn_i == vdn_ff; // RL3
   wire is_rem_src = command_source_i == sw_interlock_pkg::SRC_REMOTE ||
      command_source_i == sw_interlock_pkg::SRC_ENG;
   // Unlock only for the source that sent it, one operation
   wire unlock_hit = unlock_ff && is_rem_src &&
      unlock_src_ff == command_source_i; // RL11 RL12
   // Interlocking off: command bypass code, local mode, or remote unlock
   wire il_on = !cmd_bypass_i && // RL20
      !(command_source_i == sw_interlock_pkg::SRC_LOCAL && local_ni) && // RL10
      !unlock_hit; // RL10
   wire [3:0] auth_rsn = auth_check(auth, command_source_i, logged_ff, vmatch,
      chk_l[cmd_dev_i], chk_lre[cmd_dev_i]); // RL1 RL2
   wire prot_blk = pickup_s && (cmd_dir_i ? blk_c : blk_o); // RL16
   wire zone_blk = zone_fail(rel_en_c, rel_en_o, rel_c_s, rel_o_s, cmd_dev_i, cmd_dir_i);
   // Intermediate codes never equal a target, so the check drops out
   wire set_act = setact_en[cmd_dev_i] && cur_pos == target_pos(cmd_dir_i); // RL18 RL19

   // First failing cause wins; one reason per command
   wire [3:0] cmd_rsn =
      busy ? sw_interlock_pkg::RSN_BUSY : // RL15
      (auth_rsn != sw_interlock_pkg::RSN_NONE) ? auth_rsn :
      (il_on && prot_blk) ? sw_interlock_pkg::RSN_PROT : // RL16
      (il_on && zone_blk) ? sw_interlock_pkg::RSN_ZONE :
      set_act ? sw_interlock_pkg::RSN_SET_ACT : sw_interlock_pkg::RSN_NONE; // RL18
   wire cmd_ok = cmd_valid_i && cmd_rsn == sw_interlock_pkg::RSN_NONE;
   // Any remote or PC command from the unlocking source spends the unlock
   wire unlock_use = cmd_valid_i && unlock_hit; // RL11

   // ****************************************************************
   // Execution supervision
   // ****************************************************************
   wire [1:0] exec_pos = pos_s[2 * dev_ff +: 2];
   wire exec_done = busy && exec_pos == target_pos(dir_ff);
   // Release lost while running aborts an interlocked operation
   wire exec_zone = busy && il_ff &&
      zone_fail(rel_en_c, rel_en_o, rel_c_s, rel_o_s, dev_ff, dir_ff); // RL14
   wire exec_prot = busy && pickup_s; // RL17
   wire exec_end = exec_done || exec_zone || exec_prot;
   wire [3:0] end_cause = exec_prot ? sw_interlock_pkg::RSN_PROT :
      exec_zone ? sw_interlock_pkg::RSN_ZONE : sw_interlock_pkg::RSN_NONE;

   // Next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         sw_interlock_pkg::ST_IDLE: begin
            if (cmd_ok) begin
               nxt_state = sw_interlock_pkg::ST_EXEC;
            end
         end
         sw_interlock_pkg::ST_EXEC: begin
            if (exec_end) begin
               nxt_state = sw_interlock_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   // Software registers and read data, answered one cycle after the strobe
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_ff <= sw_interlock_pkg::CTRL_RESET;
         cfg_ff <= sw_interlock_pkg::CFG_RESET;
         reg_rdata_ff <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= reg_wdata_i & sw_interlock_pkg::CTRL_MASK;
         end
         if (wr_cfg) begin
            cfg_ff <= reg_wdata_i & sw_interlock_pkg::CFG_MASK;
         end
         reg_rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   // Engineering PC logon; a logon in the logoff cycle wins
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         logged_ff <= 1'b0;
         vdn_ff <= 8'h00;
      end else if (logon_i) begin
         logged_ff <= 1'b1; // RL3
         vdn_ff <= logon_vdn_i;
      end else if (logoff_i) begin
         logged_ff <= 1'b0; // RL3
         vdn_ff <= 8'h00;
      end
   end

   // Remote unlock; a new unlock beats the spend in the same cycle
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         unlock_ff <= 1'b0;
         unlock_src_ff <= 2'h0;
      end else if (unlock_i) begin
         unlock_ff <= 1'b1; // RL11
         unlock_src_ff <= unlock_source_i;
      end else if (unlock_use) begin
         unlock_ff <= 1'b0; // RL11
      end
   end

   // Operation held while executing; outputs drop as it ends
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_ff <= sw_interlock_pkg::ST_IDLE;
         dev_ff <= 2'h0;
         dir_ff <= 1'b0;
         il_ff <= 1'b0;
         close_ff <= 4'h0;
         open_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         if (cmd_ok && !busy) begin
            dev_ff <= cmd_dev_i;
            dir_ff <= cmd_dir_i;
            il_ff <= il_on;
            close_ff <= cmd_dir_i ? (4'h1 << cmd_dev_i) : 4'h0;
            open_ff <= cmd_dir_i ? 4'h0 : (4'h1 << cmd_dev_i);
         end else if (exec_end) begin
            close_ff <= 4'h0; // RL17
            open_ff <= 4'h0;
         end
      end
   end

   // Decision and feedback pulses; they travel on separate ports
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dec_valid_ff <= 1'b0;
         dec_accept_ff <= 1'b0;
         dec_reason_ff <= 4'h0;
         fb_valid_ff <= 1'b0;
         fb_ok_ff <= 1'b0;
         fb_cause_ff <= 4'h0;
         fb_dev_ff <= 2'h0;
         last_rsn_ff <= 4'h0;
      end else begin
         dec_valid_ff <= cmd_valid_i; // RL22
         dec_accept_ff <= cmd_ok;
         dec_reason_ff <= cmd_valid_i ? cmd_rsn : sw_interlock_pkg::RSN_NONE;
         fb_valid_ff <= exec_end; // RL21
         fb_ok_ff <= exec_end && !exec_prot && !exec_zone;
         fb_cause_ff <= exec_end ? end_cause : sw_interlock_pkg::RSN_NONE;
         fb_dev_ff <= exec_end ? dev_ff : 2'h0;
         if (cmd_valid_i) begin
            last_rsn_ff <= cmd_rsn;
         end
      end
   end

   assign reg_rdata_o = reg_rdata_ff;
   assign dec_valid_o = dec_valid_ff;
   assign dec_accept_o = dec_accept_ff;
   assign dec_reason_o = dec_reason_ff;
   assign fb_valid_o = fb_valid_ff;
   assign fb_ok_o = fb_ok_ff;
   assign fb_cause_o = fb_cause_ff;
   assign fb_dev_o = fb_dev_ff;
   assign close_o = close_ff;
   assign open_o = open_ff;

endmodule // sw_interlock

// *** verification/sw_interlock_assertions.sv ***
// Port-level concurrent checks for the switching command interlock checker
`timescale 1ns/10ps

module sw_interlock_assertions (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic cmd_valid_i,
   input wire logic [1:0] command_source_i,
   input wire logic [1:0] cmd_dev_i,
   input wire logic cmd_dir_i,
   input wire logic pickup_i,
   input wire logic dec_valid_o,
   input wire logic dec_accept_o,
   input wire logic [3:0] dec_reason_o,
   input wire logic fb_valid_o,
   input wire logic fb_ok_o,
   input wire logic [3:0] fb_cause_o,
   input wire logic [3:0] close_o,
   input wire logic [3:0] open_o
);
   // ****************************************************************
   // Decision and execution checks
   // ****************************************************************
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   // An operation is running while any switchgear output is driven
   wire logic busy = |{close_o, open_o};

   chk_dec_follows: assert property (cmd_valid_i |=> dec_valid_o)
      else $error("decision missing");
   chk_dec_cause: assert property (dec_valid_o |-> $past(cmd_valid_i))
      else $error("stray decision");
   chk_accept_code: assert property (dec_valid_o |-> dec_accept_o == (dec_reason_o == 4'h0))
      else $error("accept vs reason");
   chk_accept_drive: assert property (dec_valid_o && dec_accept_o |-> {close_o, open_o} ==
      ($past(cmd_dir_i) ? {4'h1 << $past(cmd_dev_i), 4'h0} : {4'h0, 4'h1 << $past(cmd_dev_i)}))
      else $error("wrong output driven");
   chk_busy_reject: assert property (cmd_valid_i && busy |=> dec_reason_o == 4'h5)
      else $error("busy not refused");
   chk_single_op: assert property ($onehot0({close_o, open_o}))
      else $error("two outputs driven");
   chk_auto_auth: assert property (cmd_valid_i && command_source_i == 2'h3 |=>
      dec_reason_o < 4'h1 || dec_reason_o > 4'h4)
      else $error("auto held by authority");
   chk_local_gate: assert property (cmd_valid_i && command_source_i == 2'h0 |=>
      dec_reason_o != 4'h1)
      else $error("local refused as local");
   chk_pickup_abort: assert property (pickup_i [*3] ##1 (pickup_i && busy) |=>
      fb_valid_o && !fb_ok_o && fb_cause_o == 4'h6)
      else $error("pickup no abort");
   chk_fb_end: assert property (fb_valid_o |-> $past(busy) && !busy)
      else $error("stray feedback");
   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
      else $error("stray read data");
endmodule // sw_interlock_assertions

bind sw_interlock sw_interlock_assertions chk (.*);

// *** verification/switchgear_model.sv ***
// Switchgear model: double-point position feedback answering the command outputs
`timescale 1ns/10ps

module switchgear_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] close_i,
   input wire logic [3:0] open_i,
   input wire logic stuck_i,
   output logic [7:0] pos_o
);
   logic [7:0] pos_ff;
   logic [3:0] cnt_ff;
   // Travel shows intermediate for three cycles, so a hasty end check would fail
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pos_ff <= 8'h55;
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= |{close_i, open_i} ? cnt_ff + {3'h0, cnt_ff != 4'hf} : 4'h0;
         for (int d = 0; d < 4; d++) begin
            if (close_i[d])
               pos_ff[2*d +: 2] <= cnt_ff >= 4'h3 ? sw_interlock_pkg::POS_CLOSED : 2'h0;
            if (open_i[d])
               pos_ff[2*d +: 2] <= cnt_ff >= 4'h3 ? sw_interlock_pkg::POS_OPEN : 2'h0;
         end
      end
   end
   // A faulted auxiliary contact reads intermediate on every device
   assign pos_o = stuck_i ? 8'h00 : pos_ff;
endmodule // switchgear_model

// *** verification/tb_sw_interlock.sv ***
// Self-checking bench for the switching command interlock checker
`timescale 1ns/10ps

module tb_sw_interlock;
   logic core_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic cmd_valid_i = 1'b0, cmd_dir_i = 1'b0, cmd_bypass_i = 1'b0, unlock_i = 1'b0;
   logic logon_i = 1'b0, logoff_i = 1'b0, pickup_i = 1'b0, stuck = 1'b0, logged = 1'b0;
   logic vm = 1'b1;
   logic [1:0] command_source_i = 2'h0, cmd_dev_i = 2'h0, unlock_source_i = 2'h0, fb_dev_o;
   logic [3:0] rel_close_i = 4'hf, rel_open_i = 4'hf, dec_reason_o, fb_cause_o, close_o, open_o;
   logic [7:0] reg_addr_i = 8'h00, cmd_vdn_i = 8'h00, logon_vdn_i = 8'h00, vdn = 8'h00, pos_i;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic dec_valid_o, dec_accept_o, fb_valid_o, fb_ok_o;
   int n_fail = 0, compares = 0, cyc = 0;

   always #5 core_clk_i = ~core_clk_i;

   sw_interlock dut (.core_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .cmd_valid_i, .command_source_i, .cmd_dev_i, .cmd_dir_i, .cmd_vdn_i,
      .cmd_bypass_i, .unlock_i, .unlock_source_i, .logon_i, .logoff_i, .logon_vdn_i, .pos_i,
      .rel_close_i, .rel_open_i, .pickup_i, .dec_valid_o, .dec_accept_o, .dec_reason_o,
      .fb_valid_o, .fb_ok_o, .fb_cause_o, .fb_dev_o, .close_o, .open_o);
   switchgear_model plant (.clk_i(core_clk_i), .resetn_i, .close_i(close_o), .open_i(open_o),
      .stuck_i(stuck), .pos_o(pos_i));

   // ****************************************************************
   // Shared tasks and expectations
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   // Pulse a logon (0), logoff (1) or unlock (2) event
   task automatic ev(input int k, input logic [7:0] v);
      @(posedge core_clk_i);
      logon_i <= k == 0;
      logoff_i <= k == 1;
      unlock_i <= k == 2;
      logon_vdn_i <= v;
      unlock_source_i <= v[1:0];
      @(posedge core_clk_i);
      {logon_i, logoff_i, unlock_i} <= 3'h0;
   endtask
   task automatic cmd(input logic [1:0] s, d, input logic dir, byp, input logic [3:0] e);
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b1;
      command_source_i <= s;
      cmd_dev_i <= d;
      cmd_dir_i <= dir;
      cmd_bypass_i <= byp;
      cmd_vdn_i <= vm ? vdn : ~vdn;
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
      #1 chk({dec_valid_o, dec_accept_o, dec_reason_o}, {1'b1, e == 4'h0, e});
   endtask
   // Wait a bounded time for the end of execution and check its report
   task automatic fin(input logic ok, input logic [3:0] cause, input logic [1:0] d);
      for (int i = 0; i < 40 && fb_valid_o !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk({fb_valid_o, fb_ok_o, fb_cause_o, fb_dev_o}, {1'b1, ok, cause, d});
   endtask
   // Direction that moves a device away from the position it shows
   function automatic logic away(input logic [1:0] d);
      return pos_i[2*d +: 2] != sw_interlock_pkg::POS_CLOSED;
   endfunction
   // Authority outcome; codes 1 local, 2 remote, 3 PC control, 4 not registered
   function automatic logic [3:0] exp_auth(input logic [1:0] a, s, input logic lg, v, lre);
      logic [3:0] x;
      x = 4'h0;
      if (s == 2'h2 && !(lg && v)) x = 4'h4;
      else if (a == 2'h1 && s[0] != s[1]) x = 4'h1;
      else if (a == 2'h2 && lg && s < 2'h2) x = 4'h3;
      else if (a == 2'h2 && s == 2'h0) x = 4'h2;
      if (!lre && (x == 4'h1 || (x == 4'h3 && s == 2'h1))) x = 4'h0;
      return x;
   endfunction

   // Hang guard: the run needs a few thousand cycles at most
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [1:0] a, s, d;
      logic [3:0] c, e;
      logic h;
      void'($urandom(87));
      repeat (5) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      rd(8'h00, 32'h1);
      rd(8'h04, 32'h003f_ffff);
      wr(8'h00, 32'hffff_fffb);
      rd(8'h00, 32'h3);
      rd(8'h10, 32'h0);
      $display("registers done");
      // Random authority walk, logon and logoff between commands
      for (int i = 0; i < 40; i++) begin
         a = 2'($urandom_range(2));
         s = 2'($urandom_range(3));
         d = 2'($urandom_range(3));
         vm = 1'($urandom_range(1));
         c = 4'($urandom_range(15));
         if ($urandom_range(1)) begin
            logged = 1'($urandom_range(1));
            vdn = 8'($urandom);
            ev(logged ? 0 : 1, vdn);
         end
         wr(8'h00, {30'h0, a});
         wr(8'h04, {10'h0, 14'h3fff, c, 4'hf});
         e = exp_auth(a, s, logged, vm, c[d]);
         cmd(s, d, away(d), 1'b0, e);
         if (e == 4'h0) fin(1'b1, 4'h0, d);
      end
      $display("authority done");
      // Without the local-status check a remote-control refusal becomes an accept
      ev(1, 8'h00);
      logged = 1'b0;
      rd(8'h0c, 32'h0);
      wr(8'h00, 32'h2);
      wr(8'h04, 32'h003f_fffe);
      cmd(2'h0, 2'h0, away(2'h0), 1'b0, 4'h0);
      fin(1'b1, 4'h0, 2'h0);
      // Back-to-back commands, then a command to the held position
      wr(8'h00, 32'h0);
      wr(8'h04, 32'h003f_ffff);
      cmd(2'h3, 2'h1, away(2'h1), 1'b0, 4'h0);
      cmd(2'h3, 2'h2, away(2'h2), 1'b0, 4'h5);
      rd(8'h08, 32'h0000_0511);
      fin(1'b1, 4'h0, 2'h1);
      cmd(2'h3, 2'h1, ~away(2'h1), 1'b0, 4'h8);
      $display("busy and position done");
      // Zone release missing, bypass code, release lost while executing
      {rel_close_i, rel_open_i} <= 8'h00;
      repeat (3) @(posedge core_clk_i);
      cmd(2'h3, 2'h0, away(2'h0), 1'b0, 4'h7);
      cmd(2'h3, 2'h0, away(2'h0), 1'b1, 4'h0);
      fin(1'b1, 4'h0, 2'h0);
      {rel_close_i, rel_open_i} <= 8'hff;
      repeat (3) @(posedge core_clk_i);
      cmd(2'h3, 2'h3, away(2'h3), 1'b0, 4'h0);
      {rel_close_i, rel_open_i} <= 8'h00;
      fin(1'b0, 4'h7, 2'h3);
      // Remote unlock spent once by its own source; local mode setting
      ev(2, 8'h01);
      cmd(2'h0, 2'h1, away(2'h1), 1'b0, 4'h7);
      cmd(2'h1, 2'h1, away(2'h1), 1'b0, 4'h0);
      fin(1'b1, 4'h0, 2'h1);
      cmd(2'h1, 2'h1, away(2'h1), 1'b0, 4'h7);
      wr(8'h00, 32'h4);
      cmd(2'h0, 2'h2, away(2'h2), 1'b0, 4'h0);
      fin(1'b1, 4'h0, 2'h2);
      cmd(2'h1, 2'h2, away(2'h2), 1'b0, 4'h7);
      $display("zone and unlock done");
      // Intermediate position, then pickup aborts and blocks
      {rel_close_i, rel_open_i} <= 8'hff;
      wr(8'h00, 32'h0);
      h = ~away(2'h1);
      stuck <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      cmd(2'h3, 2'h1, h, 1'b0, 4'h0);
      pickup_i <= 1'b1;
      fin(1'b0, 4'h6, 2'h1);
      cmd(2'h3, 2'h0, 1'b1, 1'b0, 4'h6);
      wr(8'h04, 32'h001f_ffff);
      cmd(2'h3, 2'h0, 1'b0, 1'b0, 4'h0);
      fin(1'b0, 4'h6, 2'h0);
      $display("protection done");
      end_of_test();
   end
endmodule // tb_sw_interlock
